// file: hdl/scr_pkg.sv
package scr_pkg;
	localparam int          ADDR_W         = 8;
	localparam int          DATA_W         = 8;
	localparam int          POS_W          = 24;
	localparam int          SEL_W          = 4;

	// Byte offsets on the serial register port
	localparam logic [7:0]  OFS_CTRL_ZERO  = 8'h29;
	localparam logic [7:0]  OFS_CTRL_ONE   = 8'h2A;
	localparam logic [7:0]  OFS_CTRL_TWO   = 8'h2B;
	localparam logic [7:0]  OFS_POS_B0     = 8'h2C;
	localparam logic [7:0]  OFS_POS_B1     = 8'h2D;
	localparam logic [7:0]  OFS_POS_B2     = 8'h2E;

	// Values after reset
	localparam logic [7:0]  RST_CTRL_ZERO  = 8'h80;
	localparam logic [7:0]  RST_CTRL_ONE   = 8'h00;
	localparam logic [7:0]  RST_CTRL_TWO   = 8'h10;
	localparam logic [23:0] RST_POS        = 24'h000000;
	localparam logic [7:0]  RST_BYTE       = 8'h00;

	// Field positions, clock control zero
	localparam int          BIT_PROC_EN    = 6;
	localparam int          BIT_RECV_EN    = 5;
	localparam int          BIT_FINE_STEP  = 4;
	localparam int          SEL_MSB        = 3;
	localparam int          SEL_LSB        = 0;
	// Clock control one
	localparam int          BIT_DEV_PECL   = 2;
	localparam int          BIT_SYS_PECL   = 1;
	localparam int          BIT_INVERT     = 0;
	// Clock control two
	localparam int          BIT_ANA_QUIET  = 2;
	localparam int          BIT_CORE_QUIET = 0;

	// Byte select codes into the capture-position store
	localparam logic [1:0]  POS_SEL_B0     = 2'h0;
	localparam logic [1:0]  POS_SEL_B1     = 2'h1;
	localparam logic [1:0]  POS_SEL_B2     = 2'h2;
endpackage

// file: hdl/scr_pos_if.sv
`timescale 1ns/1ps
interface scr_pos_if;
	logic        upd;
	logic [23:0] value;
	logic [1:0]  rd_sel;
	logic [7:0]  rd_byte;

	modport ctrl
	(
		output upd,
		output value,
		output rd_sel,
		input  rd_byte
	);
	modport store
	(
		input  upd,
		input  value,
		input  rd_sel,
		output rd_byte
	);
endinterface

// file: hdl/scr_pos_store.sv
`timescale 1ns/1ps
module scr_pos_store
(
	input  wire logic  clk,     // Device clock
	input  wire logic  rst_n,   // Async reset, active low
	input  wire logic  ce,      // Clock enable
	scr_pos_if.store   pos      // Update and read-back lanes
);
	logic [scr_pkg::POS_W-1:0] pos_q;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			pos_q <= scr_pkg::RST_POS;
		else if (ce && pos.upd)
			pos_q <= pos.value;
	end

	always_comb
	begin
		unique case (pos.rd_sel)
			scr_pkg::POS_SEL_B0: pos.rd_byte = pos_q[7:0];
			scr_pkg::POS_SEL_B1: pos.rd_byte = pos_q[15:8];
			scr_pkg::POS_SEL_B2: pos.rd_byte = pos_q[23:16];
			default:             pos.rd_byte = scr_pkg::RST_BYTE;
		endcase
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	pos_holds_still_a: assert property (!(ce && pos.upd) |=> $stable(pos_q))
		else $error("capture position changed without an update");
	pos_takes_value_a: assert property (ce && pos.upd |=> pos_q == $past(pos.value))
		else $error("capture position did not take the detector value");
endmodule // scr_pos_store

// file: hdl/scr_clock_regs.sv
// Functional notes
// - Control zero bit 6 enables SYSREF processing; reset 0; events only while set.
// - Control zero bit 5 turns the SYSREF receiver on; reset 0.
// - Control zero bit 4 selects finer window delay steps for status and delay.
// - Control zero bits 3:0 pick the SYSREF sampling delay; reset 0.
// - Control one bit 0 inverts SYSREF used for alignment; reset 0.
// - Control one bit 2 puts device clock input in PECL mode; reset 0.
// - Control one bit 1 puts SYSREF input in PECL mode; reset 0.
// - Control two bit 2 quiets the analog clock supply; reset 0.
// - Control two bit 0 quiets the clock core supply; reset 0.
// - Capture position at 0x2C is read-only status, zero after reset.
// - Capture position is a 24-bit edge location against the device clock.
`timescale 1ns/1ps
module scr_clock_regs
(
	input  wire logic        clk,                          // Device clock, 25 MHz
	input  wire logic        rst_n,                        // Async reset, active low
	input  wire logic        ce,                           // Clock enable, freezes all state
	input  wire logic        wr_en,                        // Register write strobe
	input  wire logic        rd_en,                        // Register read strobe
	input  wire logic [7:0]  addr,                         // Register byte offset
	input  wire logic [7:0]  wr_data,                      // Write byte
	output logic      [7:0]  rd_data,                      // Read byte, valid with rd_valid
	output logic             rd_valid,                     // Read answer pulse
	input  wire logic        sysref_pin,                   // Raw SYSREF level from the receiver pad
	input  wire logic        edge_pos_valid,               // Detector has a new edge position
	input  wire logic [23:0] edge_pos_value,               // Detector edge position
	output logic             sysref_receiver_enable,       // Receiver power-on
	output logic             sysref_processor_enable,      // Processor enable
	output logic             window_fine_step_select,      // Fine window steps
	output logic      [3:0]  sysref_delay_select,          // Sampling delay choice
	output logic             sysref_polarity_invert,       // Alignment polarity invert
	output logic             device_clock_pecl_mode,       // Device clock PECL mode
	output logic             sysref_pecl_mode,             // SYSREF PECL mode
	output logic             analog_clock_supply_quieting, // Analog clock supply quieting
	output logic             clock_core_supply_quieting,   // Clock core supply quieting
	output logic             sysref_aligned,               // Conditioned SYSREF level
	output logic             sysref_event                  // One-cycle SYSREF event pulse
);
	logic [7:0]  ctrl_zero_q;
	logic [7:0]  ctrl_one_q;
	logic [7:0]  ctrl_two_q;
	logic [7:0]  rd_data_q;
	logic        rd_valid_q;
	logic        sync1_q;
	logic        sync2_q;
	logic        aligned_q;
	logic        event_q;
	logic [7:0]  rd_mux;
	logic        hit_pos;
	logic        wr_zero;
	logic        wr_one;
	logic        wr_two;

	scr_pos_if pos_if ();

	scr_pos_store u_pos
	(
		.clk   (clk),
		.rst_n (rst_n),
		.ce    (ce),
		.pos   (pos_if.store)
	);

	assign wr_zero = wr_en && (addr == scr_pkg::OFS_CTRL_ZERO);
	assign wr_one  = wr_en && (addr == scr_pkg::OFS_CTRL_ONE);
	assign wr_two  = wr_en && (addr == scr_pkg::OFS_CTRL_TWO);
	assign hit_pos = (addr == scr_pkg::OFS_POS_B0) || (addr == scr_pkg::OFS_POS_B1) ||
	                 (addr == scr_pkg::OFS_POS_B2);

	// Reserved bits are stored as written, so a host that follows the rules reads its own value back
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			ctrl_zero_q <= scr_pkg::RST_CTRL_ZERO;
		else if (ce && wr_zero)
			ctrl_zero_q <= wr_data;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			ctrl_one_q <= scr_pkg::RST_CTRL_ONE;
		else if (ce && wr_one)
			ctrl_one_q <= wr_data;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			ctrl_two_q <= scr_pkg::RST_CTRL_TWO;
		else if (ce && wr_two)
			ctrl_two_q <= wr_data;
	end

	// Position store only follows the detector; no register write reaches it
	assign pos_if.upd   = edge_pos_valid && ctrl_zero_q[scr_pkg::BIT_PROC_EN];
	assign pos_if.value = edge_pos_value;

	always_comb
	begin
		pos_if.rd_sel = scr_pkg::POS_SEL_B0;
		if (addr == scr_pkg::OFS_POS_B1)
			pos_if.rd_sel = scr_pkg::POS_SEL_B1;
		else if (addr == scr_pkg::OFS_POS_B2)
			pos_if.rd_sel = scr_pkg::POS_SEL_B2;
	end

	always_comb
	begin
		rd_mux = scr_pkg::RST_BYTE;
		if (addr == scr_pkg::OFS_CTRL_ZERO)
			rd_mux = ctrl_zero_q;
		else if (addr == scr_pkg::OFS_CTRL_ONE)
			rd_mux = ctrl_one_q;
		else if (addr == scr_pkg::OFS_CTRL_TWO)
			rd_mux = ctrl_two_q;
		else if (hit_pos)
			rd_mux = pos_if.rd_byte;
	end

	// Unmapped offsets answer zero so a stray read never stalls the port
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rd_data_q  <= scr_pkg::RST_BYTE;
			rd_valid_q <= 1'b0;
		end
		else if (ce)
		begin
			rd_valid_q <= rd_en;
			if (rd_en)
				rd_data_q <= rd_mux;
		end
	end

	// Pad level is asynchronous to the device clock
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
		end
		else if (ce)
		begin
			sync1_q <= sysref_pin;
			sync2_q <= sync1_q;
		end
	end

	// A disabled receiver presents a quiet low level, whatever the polarity
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			aligned_q <= 1'b0;
		else if (ce)
			aligned_q <= (sync2_q ^ ctrl_one_q[scr_pkg::BIT_INVERT]) && ctrl_zero_q[scr_pkg::BIT_RECV_EN];
	end

	// Processor events fire only when the receiver is up too, covering a host that breaks the order
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			event_q <= 1'b0;
		else if (ce)
			event_q <= (sync2_q ^ ctrl_one_q[scr_pkg::BIT_INVERT]) && !aligned_q &&
			           ctrl_zero_q[scr_pkg::BIT_RECV_EN] && ctrl_zero_q[scr_pkg::BIT_PROC_EN];
	end

	assign rd_data                      = rd_data_q;
	assign rd_valid                     = rd_valid_q;
	assign sysref_receiver_enable       = ctrl_zero_q[scr_pkg::BIT_RECV_EN];
	assign sysref_processor_enable      = ctrl_zero_q[scr_pkg::BIT_PROC_EN];
	assign window_fine_step_select      = ctrl_zero_q[scr_pkg::BIT_FINE_STEP];
	assign sysref_delay_select          = ctrl_zero_q[scr_pkg::SEL_MSB:scr_pkg::SEL_LSB];
	assign sysref_polarity_invert       = ctrl_one_q[scr_pkg::BIT_INVERT];
	assign device_clock_pecl_mode       = ctrl_one_q[scr_pkg::BIT_DEV_PECL];
	assign sysref_pecl_mode             = ctrl_one_q[scr_pkg::BIT_SYS_PECL];
	assign analog_clock_supply_quieting = ctrl_two_q[scr_pkg::BIT_ANA_QUIET];
	assign clock_core_supply_quieting   = ctrl_two_q[scr_pkg::BIT_CORE_QUIET];
	assign sysref_aligned               = aligned_q;
	assign sysref_event                 = event_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence rd_req_s(logic [7:0] a);
		ce && rd_en && (addr == a);
	endsequence

	sequence wr_req_s(logic [7:0] a);
		ce && wr_en && (addr == a);
	endsequence

	event_needs_proc_a: assert property (sysref_event && $past(ce) |-> $past(ctrl_zero_q[scr_pkg::BIT_PROC_EN]))
		else $error("SYSREF event while processor disabled");
	event_needs_recv_a: assert property (sysref_event && $past(ce) |-> $past(ctrl_zero_q[scr_pkg::BIT_RECV_EN]))
		else $error("SYSREF event while receiver disabled");
	zero_write_a: assert property (wr_req_s(scr_pkg::OFS_CTRL_ZERO) |=>
		window_fine_step_select == $past(wr_data[4]) && sysref_delay_select == $past(wr_data[3:0]))
		else $error("fine step or delay select missed a write");
	delay_hold_a: assert property (!(ce && wr_zero) |=> $stable(sysref_delay_select))
		else $error("delay select changed without a write");
	// Compare against the polarity that was in force at the launching edge, so a write to it is no false alarm
	invert_path_a: assert property (ce && sysref_receiver_enable |=>
		sysref_aligned == ($past(sync2_q) ^ $past(sysref_polarity_invert)))
		else $error("aligned SYSREF does not follow polarity setting");
	one_write_a: assert property (wr_req_s(scr_pkg::OFS_CTRL_ONE) |=>
		device_clock_pecl_mode == $past(wr_data[2]) && sysref_pecl_mode == $past(wr_data[1]))
		else $error("PECL mode bits missed a write");
	two_write_a: assert property (wr_req_s(scr_pkg::OFS_CTRL_TWO) |=>
		analog_clock_supply_quieting == $past(wr_data[2]) && clock_core_supply_quieting == $past(wr_data[0]))
		else $error("supply quieting bits missed a write");
	pos_read_a: assert property (rd_req_s(scr_pkg::OFS_POS_B0) |=> rd_valid && rd_data == $past(pos_if.rd_byte))
		else $error("capture position read returned wrong byte");
	pos_write_ignored_a: assert property (ce && wr_en && hit_pos && !edge_pos_valid |=>
		$stable(u_pos.pos_q) && $stable(ctrl_zero_q) && $stable(ctrl_one_q))
		else $error("write to capture position disturbed control state");
	core_quiet_hold_a: assert property (!(ce && wr_two) |=> $stable(clock_core_supply_quieting))
		else $error("core quieting changed without a write");
endmodule // scr_clock_regs

// file: tb/scr_host.sv
`timescale 1ns/1ps
module scr_host
(
	input  wire logic       clk,      // Device clock
	output logic            wr_en,    // Write strobe
	output logic            rd_en,    // Read strobe
	output logic      [7:0] addr,     // Register offset
	output logic      [7:0] wr_data,  // Write byte
	input  wire logic [7:0] rd_data,  // Read byte
	input  wire logic       rd_valid  // Read answer pulse
);
	logic [7:0] shadow0 = 8'h80;
	initial
	begin
		wr_en   = 1'b0;
		rd_en   = 1'b0;
		addr    = 8'h00;
		wr_data = 8'h00;
	end
	task automatic put(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr_en   <= 1'b1;
		addr    <= a;
		wr_data <= d;
		@(posedge clk);
		wr_en   <= 1'b0;
	endtask
	// Receiver goes on first, so a write raising both is split in two
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		if (a == scr_pkg::OFS_CTRL_ZERO && d[6] && !shadow0[5])
			put(a, d & 8'hBF);
		put(a, d);
		if (a == scr_pkg::OFS_CTRL_ZERO)
			shadow0 = d;
	endtask
	// Answer is due on the same edge that takes the read
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		rd_en <= 1'b1;
		addr  <= a;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		d = (rd_valid === 1'b1) ? rd_data : 8'hXX;
	endtask
endmodule // scr_host

// file: tb/scr_clock_regs_bench.sv
`timescale 1ns/1ps
module scr_clock_regs_bench;
	logic        clk = 1'b0, rst_n = 1'b0, ce = 1'b1, wr_en, rd_en, rv, pin = 1'b0, epv = 1'b0;
	logic [7:0]  addr, wd, rdat;
	logic [23:0] epval = 24'h000000;
	logic [23:0] mpos = 24'h000000;
	logic [7:0]  m0 = 8'h80, m1 = 8'h00, m2 = 8'h10, g;
	logic        rx, px, fs, inv, dp, sp, aq, cq, al, ev;
	logic [3:0]  ds;
	logic [31:0] lf = 32'h5F58;
	int          fail_count = 0, n_checks = 0, cyc = 0, ev_n = 0;
	always #20 clk = ~clk;
	scr_host i_scr_host (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wd), .rd_data(rdat),
		.rd_valid(rv));
	scr_clock_regs i_scr_clock_regs (.clk(clk), .rst_n(rst_n), .ce(ce), .wr_en(wr_en), .rd_en(rd_en),
		.addr(addr), .wr_data(wd), .rd_data(rdat), .rd_valid(rv), .sysref_pin(pin), .edge_pos_valid(epv),
		.edge_pos_value(epval), .sysref_receiver_enable(rx), .sysref_processor_enable(px),
		.window_fine_step_select(fs), .sysref_delay_select(ds), .sysref_polarity_invert(inv),
		.device_clock_pecl_mode(dp), .sysref_pecl_mode(sp), .analog_clock_supply_quieting(aq),
		.clock_core_supply_quieting(cq), .sysref_aligned(al), .sysref_event(ev));
	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [7:0] mexp(input logic [7:0] a);
		case (a)
			8'h29:   return m0;
			8'h2A:   return m1;
			8'h2B:   return m2;
			8'h2C:   return mpos[7:0];
			8'h2D:   return mpos[15:8];
			8'h2E:   return mpos[23:16];
			default: return 8'h00;
		endcase
	endfunction
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("MISMATCH t=%0t read got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_lvl(input logic [11:0] got, input logic [11:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("MISMATCH t=%0t levels got %h exp %h", $time, got, exp);
		end
	endtask
	// Sweeps all mapped bytes plus one unmapped neighbour
	task automatic sweep;
		for (int a = 8'h29; a <= 8'h2F; a++)
		begin
			i_scr_host.rd(a[7:0], g);
			chk_rd(g, mexp(a[7:0]));
		end
	endtask
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (ev === 1'b1)
			ev_n++;
		if (cyc == 3000)
		begin
			fail_count++;
			tally_and_finish();
		end
	end
	initial
	begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		sweep();
		for (int i = 0; i < 8; i++)
		begin
			lf = nx(lf);
			// Processor enable never goes up without the receiver enable beside it
			m0 = {1'b1, lf[6], lf[5] | lf[6], lf[4:0]};
			m1 = {5'h00, lf[10:8]};
			m2 = {5'h02, lf[13], 1'b0, lf[14]};
			i_scr_host.wr(8'h29, m0);
			i_scr_host.wr(8'h2A, m1);
			i_scr_host.wr(8'h2B, m2);
			@(posedge clk);
			#1 chk_lvl({px, rx, fs, ds, dp, sp, inv, aq, cq}, {m0[6:0], m1[2:0], m2[2], m2[0]});
			@(posedge clk);
			epv   <= 1'b1;
			epval <= lf[31:8];
			@(posedge clk);
			epv <= 1'b0;
			if (m0[6])
				mpos = epval;
			i_scr_host.wr(8'h2C, ~mpos[7:0]);
			sweep();
			ev_n = 0;
			@(posedge clk);
			pin <= 1'b1;
			repeat (5) @(posedge clk);
			#1 chk_lvl({11'h000, al}, {11'h000, ~m1[0] & m0[5]});
			@(posedge clk);
			pin <= 1'b0;
			repeat (5) @(posedge clk);
			#1 chk_rd(8'(ev_n), {7'h00, m0[5] & m0[6]});
		end
		// Host tunes the window from the position it reads back; several set bits mean several windows
		i_scr_host.rd(scr_pkg::OFS_POS_B0, g);
		chk_rd(g, mexp(scr_pkg::OFS_POS_B0));
		m0 = {m0[7:5], (g & (g - 8'h01)) != 8'h00, g[3:0]};
		i_scr_host.wr(scr_pkg::OFS_CTRL_ZERO, m0);
		// A write offered while the clock enable is low must not be taken
		@(posedge clk);
		ce <= 1'b0;
		i_scr_host.wr(scr_pkg::OFS_CTRL_TWO, m2 ^ 8'h05);
		ce <= 1'b1;
		@(posedge clk);
		#1 chk_lvl({px, rx, fs, ds, dp, sp, inv, aq, cq}, {m0[6:0], m1[2:0], m2[2], m2[0]});
		tally_and_finish();
	end
endmodule // scr_clock_regs_bench
